// >>> rtl/bit_sync.sv
// Two-flop synchroniser for pin inputs
// Assumes the inputs are asynchronous to clk
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  // First stage, read only by the second
  logic [WIDTH-1:0] meta_ff;

  // Idle-level reset keeps the receiver from seeing a false start
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta_ff <= INIT;
      level_out <= INIT;
    end
    else
    begin
      meta_ff <= pin_in;
      level_out <= meta_ff;
    end
  end

endmodule

// >>> rtl/rx_sampler.sv
// Oversampling receive counter with three-point majority vote
// Assumes os_tick is a one-cycle pulse on clk
`timescale 1ns/1ps
`include "serial_channel_defs.svh"
module rx_sampler #(
  parameter int CNT_W = 4
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic restart,
  input wire logic os_tick,
  input wire logic rx_level,
  output logic bit_done,
  output logic bit_value
);
  import serial_channel_pkg::*;

  logic [CNT_W-1:0] cnt_ff; // Oversample pulses within the bit
  logic s_a_ff; // Sample at the 7th pulse
  logic s_b_ff; // Sample at the 8th pulse

  // Counter wraps every 16 pulses, so bits follow on without restart
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      cnt_ff <= '0;
    else if (restart)
      cnt_ff <= '0;
    else if (os_tick)
      cnt_ff <= cnt_ff + CNT_W'(1);
  end

  // Samples at pulses 7, 8 and 9, decision at the 9th
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s_a_ff <= 1'b1;
      s_b_ff <= 1'b1;
      bit_done <= 1'b0;
      bit_value <= 1'b1;
    end
    else
    begin
      bit_done <= 1'b0;
      if (os_tick && !restart)
      begin
        if (cnt_ff == `SCC_SAMPLE_A)
          s_a_ff <= rx_level;
        if (cnt_ff == `SCC_SAMPLE_B)
          s_b_ff <= rx_level;
        if (cnt_ff == `SCC_SAMPLE_C)
        begin
          bit_done <= 1'b1;
          bit_value <= majority3(s_a_ff, s_b_ff, rx_level);
        end
      end
    end
  end

endmodule

// >>> rtl/serial_channel_core.sv
// Serial channel datapath: clock selection, receive and transmit
// sequencers, double-buffered receive, parity and error flags.
// Assumes tick inputs are one-cycle pulses on clk; pins are async.
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "serial_channel_defs.svh"
module serial_channel_core #(
  parameter int CHANNEL_ID = 1
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic baud_tick,
  input wire logic fixed_tick,
  input wire logic timer0_match,
  input wire logic rxd_pin,
  input wire logic sclk_in_pin,
  input wire logic clear_to_send_in,
  output logic txd,
  output logic sclk_out,
  output logic sclk_oe,
  output logic receive_irq,
  output logic transmit_irq
);
  import serial_channel_pkg::*;

  // Bus handshake: one wait cycle per access
  logic ack_ff;
  logic bus_req;
  logic rd_acc;
  logic wr_acc;
  logic rd_snap_full_ff; // Buffer state seen when the read was sampled

  // Control fields
  logic [15:0] ctrl_ff;
  frame_mode_t mode;
  logic [1:0] clock_source_field;
  logic clock_direction_sel;
  logic edge_select;
  logic parity_enable;
  logic parity_odd;
  logic wakeup_enable;
  logic handshake_enable;
  logic transmit_ninth_bit;
  logic receive_enable;

  // Status and buffers
  logic [7:0] data_buffer_ff; // Second receive stage
  logic received_ninth_bit_ff;
  logic rx_full_ff;
  logic parity_error_flag_ff;
  logic overrun_flag_ff;
  logic framing_error_flag_ff;
  logic [7:0] tx_data_ff; // Transmit buffer
  logic tx_ninth_ff;
  logic tx_full_ff;

  // Synchronised pins
  logic rxd_s;
  logic sclk_s;
  logic cts_s;
  logic sclk_d_ff;

  // Clocking
  logic os_tick;
  logic async_mode;
  logic sync_mode;
  logic [3:0] tx_cnt_ff;
  logic bit_rise;
  logic bit_fall;
  logic sclk_ff;
  logic sync_shift;

  // Receive path
  rx_state_t rx_state_ff;
  logic bit_done;
  logic bit_value;
  logic rx_restart;
  logic [8:0] rx_sh_ff; // First receive stage
  logic [3:0] rx_cnt_ff;
  logic rx_take;
  logic [8:0] nxt_rx_sh;
  logic [8:0] rx_aligned;
  logic [3:0] rx_n;
  logic deliver;
  logic wake_pass;
  logic rx_parity_bad;
  logic rx_last; // Final payload bit decided

  // Transmit path
  tx_state_t tx_state_ff;
  logic [10:0] tx_sh_ff;
  logic [3:0] tx_left_ff;
  logic cts_wait_ff;
  logic hold;
  logic start_async;
  logic start_sync;
  logic tx_done;
  logic [8:0] tx_payload;
  logic data_wr;
  logic [7:0] wr_byte;

  assign mode = frame_mode_t'(ctrl_ff[`SCC_CTRL_MODE_LO +: 2]);
  assign clock_source_field = ctrl_ff[`SCC_CTRL_SRC_LO +: 2];
  assign clock_direction_sel = ctrl_ff[`SCC_CTRL_DIR];
  assign edge_select = ctrl_ff[`SCC_CTRL_EDGE];
  assign parity_enable = ctrl_ff[`SCC_CTRL_PE];
  assign parity_odd = ctrl_ff[`SCC_CTRL_ODD];
  assign wakeup_enable = ctrl_ff[`SCC_CTRL_WU];
  assign handshake_enable = ctrl_ff[`SCC_CTRL_HS];
  assign transmit_ninth_bit = ctrl_ff[`SCC_CTRL_TB9];
  assign receive_enable = ctrl_ff[`SCC_CTRL_RXEN];

  assign async_mode = (mode != MODE_SHIFT);
  // Shift mode is absent on channel 0; code 00 idles there
  assign sync_mode = (mode == MODE_SHIFT) && (CHANNEL_ID == 1);

  // Pins cross into clk through two flops
  bit_sync #(.WIDTH(3), .INIT(3'b110)) u_pins (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in({rxd_pin, sclk_in_pin, clear_to_send_in}),
    .level_out({rxd_s, sclk_s, cts_s})
  );

  // ---- Register bus ----
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_ff;
  assign rd_acc = bus_req & ack_ff & avs_read;
  assign wr_acc = bus_req & ack_ff & avs_write;
  assign data_wr = wr_acc && avs_address == `SCC_OFS_DATA
                   && avs_byteenable[0] && !tx_full_ff;

  // Ack after one wait cycle; read data sampled in the wait cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ack_ff <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      rd_snap_full_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= bus_req & ~ack_ff;
      if (avs_read && !ack_ff)
      begin
        rd_snap_full_ff <= rx_full_ff;
        case (avs_address)
          `SCC_OFS_DATA: avs_readdata <= {24'h00_0000, data_buffer_ff};
          `SCC_OFS_CTRL: avs_readdata <= {16'h0000, ctrl_ff};
          `SCC_OFS_STATUS:
          begin
            avs_readdata <= 32'h0000_0000;
            avs_readdata[`SCC_ST_RXFULL] <= rx_full_ff;
            avs_readdata[`SCC_ST_TXFULL] <= tx_full_ff;
            avs_readdata[`SCC_ST_NINTH] <= received_ninth_bit_ff;
            avs_readdata[`SCC_ST_PARITY_ERROR_FLAG] <= parity_error_flag_ff;
            avs_readdata[`SCC_ST_OVERRUN_FLAG] <= overrun_flag_ff;
            avs_readdata[`SCC_ST_FRAMING_ERROR_FLAG] <= framing_error_flag_ff;
            avs_readdata[`SCC_ST_TXBUSY] <= (tx_state_ff != TX_IDLE);
          end
          // Unmapped reads as zero
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control register, byte lanes 0 and 1
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      ctrl_ff <= `SCC_CTRL_RESET;
    else if (wr_acc && avs_address == `SCC_OFS_CTRL)
    begin
      if (avs_byteenable[0])
        ctrl_ff[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1])
        ctrl_ff[15:8] <= avs_writedata[15:8] & 8'(`SCC_CTRL_MASK >> 8);
    end
  end

  // ---- Clock generation ----
  // Oversample clock selection
  always_comb
  begin
    case (clock_source_field)
      2'b00: os_tick = timer0_match;
      2'b01: os_tick = baud_tick;
      2'b10: os_tick = fixed_tick;
      default: os_tick = baud_tick;
    endcase
  end

  // Transmit bit clock: high half is counts 8..15
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      tx_cnt_ff <= 4'h0;
    else if (async_mode && os_tick)
      tx_cnt_ff <= tx_cnt_ff + 4'h1;
  end
  assign bit_rise = async_mode && os_tick
                    && tx_cnt_ff == `SCC_TX_RISE_CNT;
  assign bit_fall = async_mode && os_tick && tx_cnt_ff == `SCC_TX_FALL_CNT;

  // Output shift clock toggles per baud tick, idles high
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      sclk_ff <= 1'b1;
    else if (tx_state_ff == TX_SYNC && !clock_direction_sel)
    begin
      if (baud_tick)
        sclk_ff <= ~sclk_ff;
    end
    else
      sclk_ff <= 1'b1;
  end
  assign sclk_out = sclk_ff;
  assign sclk_oe = sync_mode && !clock_direction_sel;

  // Edge history of the external shift clock
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      sclk_d_ff <= 1'b1;
    else
      sclk_d_ff <= sclk_s;
  end

  // One shift event per rising output edge or selected input edge
  always_comb
  begin
    sync_shift = 1'b0;
    if (tx_state_ff == TX_SYNC)
    begin
      if (!clock_direction_sel)
        sync_shift = baud_tick && !sclk_ff;
      else if (!edge_select)
        sync_shift = sclk_s && !sclk_d_ff;
      else
        sync_shift = !sclk_s && sclk_d_ff;
    end
  end

  // ---- Receive ----
  rx_sampler #(.CNT_W(4)) u_sampler (
    .clk(clk),
    .rst_b(rst_b),
    .restart(rx_restart),
    .os_tick(os_tick),
    .rx_level(rxd_s),
    .bit_done(bit_done),
    .bit_value(bit_value)
  );
  assign rx_restart = rx_state_ff == RX_IDLE && async_mode && !rxd_s;

  // Frame sequencer for asynchronous modes
  always_ff @(posedge clk)
  begin
    if (!rst_b || !async_mode)
      rx_state_ff <= RX_IDLE;
    else
    begin
      case (rx_state_ff)
        RX_IDLE:
          if (rx_restart)
            rx_state_ff <= RX_START;
        RX_START:
          if (bit_done)
            rx_state_ff <= bit_value ? RX_IDLE : RX_DATA;
        RX_DATA:
          if (rx_last)
            rx_state_ff <= RX_STOP;
        RX_STOP:
          if (bit_done)
            rx_state_ff <= RX_IDLE;
        default: rx_state_ff <= RX_IDLE;
      endcase
    end
  end

  // Last payload bit reached in asynchronous reception
  assign rx_last = rx_state_ff == RX_DATA && bit_done
                   && rx_cnt_ff + 4'h1 == rx_n;

  // Bits enter from the top so the first bit ends lowest
  assign rx_take = (rx_state_ff == RX_DATA && bit_done) || sync_shift;
  assign nxt_rx_sh = {sync_shift ? rxd_s : bit_value, rx_sh_ff[8:1]};
  assign rx_n = sync_mode ? `SCC_SYNC_BITS
                : frame_bits(mode, parity_enable);
  assign rx_aligned = nxt_rx_sh >> (`SCC_MAX_BITS - rx_n);
  assign deliver = sync_mode
                   ? (sync_shift && tx_left_ff == 4'h1 && receive_enable)
                   : rx_last;
  assign wake_pass = !(mode == MODE_9BIT && wakeup_enable
                       && !rx_aligned[8]);
  // Parity is only defined for 7 and 8-bit modes
  assign rx_parity_bad = parity_enable
      && (mode == MODE_7BIT || mode == MODE_8BIT)
      && parity_bit(rx_aligned[7:0], mode == MODE_7BIT, parity_odd)
         != (mode == MODE_7BIT ? rx_aligned[7] : rx_aligned[8]);

  // First stage shift register and bit count
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rx_sh_ff <= 9'h1FF;
      rx_cnt_ff <= 4'h0;
    end
    else if (rx_state_ff == RX_START || start_sync)
      rx_cnt_ff <= 4'h0;
    else if (rx_take)
    begin
      rx_sh_ff <= nxt_rx_sh;
      rx_cnt_ff <= rx_cnt_ff + 4'h1;
    end
  end

  // Second stage: copy, overrun, error flags; set beats clear
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      data_buffer_ff <= 8'h00;
      received_ninth_bit_ff <= 1'b0;
      rx_full_ff <= 1'b0;
      parity_error_flag_ff <= 1'b0;
      overrun_flag_ff <= 1'b0;
      framing_error_flag_ff <= 1'b0;
      receive_irq <= 1'b0;
    end
    else
    begin
      receive_irq <= 1'b0;
      // Reads clear only what the CPU actually saw
      if (rd_acc && avs_address == `SCC_OFS_DATA && rd_snap_full_ff)
        rx_full_ff <= 1'b0;
      if (rd_acc && avs_address == `SCC_OFS_STATUS)
      begin
        if (avs_readdata[`SCC_ST_PARITY_ERROR_FLAG])
          parity_error_flag_ff <= 1'b0;
        if (avs_readdata[`SCC_ST_OVERRUN_FLAG])
          overrun_flag_ff <= 1'b0;
        if (avs_readdata[`SCC_ST_FRAMING_ERROR_FLAG])
          framing_error_flag_ff <= 1'b0;
      end
      if (deliver && wake_pass)
      begin
        if (rx_full_ff && !(rd_acc && avs_address == `SCC_OFS_DATA
                            && rd_snap_full_ff))
          overrun_flag_ff <= 1'b1;
        else
        begin
          data_buffer_ff <= rx_aligned[7:0];
          received_ninth_bit_ff <= (mode == MODE_8BIT
                                    || mode == MODE_9BIT)
                                   && rx_aligned[8];
          rx_full_ff <= 1'b1;
          receive_irq <= 1'b1;
          if (rx_parity_bad)
            parity_error_flag_ff <= 1'b1;
        end
      end
      if (rx_state_ff == RX_STOP && bit_done && !bit_value)
        framing_error_flag_ff <= 1'b1;
    end
  end

  // ---- Transmit ----
  // Parity is fixed at write time from the settings then in force
  assign wr_byte = avs_writedata[7:0];
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      tx_data_ff <= 8'h00;
      tx_ninth_ff <= 1'b0;
      tx_full_ff <= 1'b0;
    end
    else if (data_wr)
    begin
      tx_data_ff <= wr_byte;
      if (parity_enable && mode == MODE_7BIT)
        tx_data_ff[7] <= parity_bit(wr_byte, 1'b1, parity_odd);
      tx_ninth_ff <= (mode == MODE_9BIT) ? transmit_ninth_bit
                     : parity_bit(wr_byte, 1'b0, parity_odd);
      tx_full_ff <= 1'b1;
    end
    else if (tx_done)
      tx_full_ff <= 1'b0;
  end

  // Handshake exists on channel 0 only; checked between frames
  assign hold = handshake_enable && CHANNEL_ID == 0 && cts_s;

  // Remember a held frame so it resumes on a falling bit-clock edge
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      cts_wait_ff <= 1'b0;
    else if (start_async)
      cts_wait_ff <= 1'b0;
    else if (tx_state_ff == TX_IDLE && tx_full_ff && hold)
      cts_wait_ff <= 1'b1;
  end

  assign start_async = tx_state_ff == TX_IDLE && async_mode && tx_full_ff
                       && !hold
                       && (cts_wait_ff ? bit_fall : bit_rise);
  assign start_sync = tx_state_ff == TX_IDLE && sync_mode
                      && (tx_full_ff || (receive_enable && !rx_full_ff));
  // Buffer empties as the stop bit starts, or after the last shift
  assign tx_done = tx_full_ff
      && ((tx_state_ff == TX_ASYNC && bit_rise && tx_left_ff == 4'h2)
          || (sync_shift && tx_left_ff == 4'h1));
  assign transmit_irq = tx_done;

  // Payload padded with ones past its length, so stop follows
  always_comb
  begin
    tx_payload = {tx_ninth_ff, tx_data_ff};
    for (int i = 0; i < 9; i++)
      if (4'(i) >= frame_bits(mode, parity_enable))
        tx_payload[i] = 1'b1;
  end

  // Shifter: start bit, payload LSB first, stop; shift mode sends the 8 data bits alone
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      tx_state_ff <= TX_IDLE;
      tx_sh_ff <= 11'h7FF;
      tx_left_ff <= 4'h0;
    end
    else
    begin
      case (tx_state_ff)
        TX_IDLE:
          if (start_async)
          begin
            tx_sh_ff <= {1'b1, tx_payload, 1'b0};
            tx_left_ff <= frame_bits(mode, parity_enable) + 4'h2;
            tx_state_ff <= TX_ASYNC;
          end
          else if (start_sync)
          begin
            tx_sh_ff <= {3'b111, tx_full_ff ? tx_data_ff : 8'hFF};
            tx_left_ff <= `SCC_SYNC_BITS;
            tx_state_ff <= TX_SYNC;
          end
        TX_ASYNC:
          if (bit_rise)
          begin
            tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
            tx_left_ff <= tx_left_ff - 4'h1;
            if (tx_left_ff == 4'h1)
              tx_state_ff <= TX_IDLE;
          end
        TX_SYNC:
          if (sync_shift)
          begin
            tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
            tx_left_ff <= tx_left_ff - 4'h1;
            if (tx_left_ff == 4'h1)
              tx_state_ff <= TX_IDLE;
          end
        default: tx_state_ff <= TX_IDLE;
      endcase
    end
  end
  assign txd = tx_sh_ff[0];

endmodule

// >>> shared/serial_channel_defs.svh
// Register map, field positions, reset values and timing counts
// Assumes a 32-bit Avalon-MM slave with byte addresses on 4 bits
`ifndef SERIAL_CHANNEL_DEFS_SVH
`define SERIAL_CHANNEL_DEFS_SVH

// Register byte offsets
`define SCC_OFS_DATA 4'h0
`define SCC_OFS_CTRL 4'h4
`define SCC_OFS_STATUS 4'h8

// Control register fields
`define SCC_CTRL_MODE_LO 0
`define SCC_CTRL_SRC_LO 2
`define SCC_CTRL_DIR 4
`define SCC_CTRL_EDGE 5
`define SCC_CTRL_PE 6
`define SCC_CTRL_ODD 7
`define SCC_CTRL_WU 8
`define SCC_CTRL_HS 9
`define SCC_CTRL_TB9 10
`define SCC_CTRL_RXEN 11
`define SCC_CTRL_MASK 16'h0FFF
`define SCC_CTRL_RESET 16'h0000

// Status register fields
`define SCC_ST_RXFULL 0
`define SCC_ST_TXFULL 1
`define SCC_ST_NINTH 2
`define SCC_ST_PARITY_ERROR_FLAG 3
`define SCC_ST_OVERRUN_FLAG 4
`define SCC_ST_FRAMING_ERROR_FLAG 5
`define SCC_ST_TXBUSY 6

// Oversampling and shift timing
`define SCC_SAMPLE_A 4'h6
`define SCC_SAMPLE_B 4'h7
`define SCC_SAMPLE_C 4'h8
`define SCC_TX_RISE_CNT 4'h7
`define SCC_TX_FALL_CNT 4'hF
`define SCC_SYNC_BITS 4'h8
`define SCC_MAX_BITS 4'h9

`endif

// >>> shared/serial_channel_pkg.sv
// Types and shared helpers of the serial channel
// Assumes the constants header is compiled alongside
package serial_channel_pkg;

  // Frame mode field decode, in field-code order
  typedef enum logic [1:0] {MODE_SHIFT, MODE_7BIT, MODE_8BIT, MODE_9BIT}
    frame_mode_t;

  // Receive and transmit sequencer states
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} tx_state_t;

  // Two of three samples decide
  function automatic logic majority3(input logic a, input logic b,
                                     input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  // Parity over 7 or 8 data bits, even or odd
  function automatic logic parity_bit(input logic [7:0] d,
                                      input logic seven, input logic odd);
    logic p;
    p = seven ? ^d[6:0] : ^d;
    return odd ? ~p : p;
  endfunction

  // Bits after the start bit, stop excluded
  function automatic logic [3:0] frame_bits(input frame_mode_t m,
                                            input logic pe);
    logic [3:0] n;
    n = 4'h7;
    if (m != MODE_7BIT || pe)
      n = n + 4'h1;
    if (m == MODE_9BIT || (m == MODE_8BIT && pe))
      n = n + 4'h1;
    return n;
  endfunction

endpackage

// >>> testbench/remote_uart.sv
// Remote serial party: sends frames and captures them
// Assumes BIT clk cycles per bit and an idle-high line
`timescale 1ns/1ps
module remote_uart #(
  parameter int BIT = 32
)(
  input wire logic clk,
  input wire logic txd,
  input wire logic sclk,
  output logic rxd
);
  // Line idles high between frames
  initial rxd = 1'b1;
  // Start low, n bits LSB first, then stop level s
  task automatic send(input logic [9:0] d, input int n, input logic s);
    rxd <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      rxd <= d[i];
      repeat (BIT) @(posedge clk);
    end
    rxd <= s;
    repeat (BIT) @(posedge clk);
    rxd <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
  // Mid-bit capture of n bits, stop level lands in d[n]
  task automatic rcv(input int n, output logic [9:0] d);
    d = 10'h0;
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i <= n; i++)
    begin
      repeat (BIT) @(posedge clk);
      d[i] = txd;
    end
  endtask
  // Shift capture: txd only moves on rising sclk, so read it on the fall
  task automatic shift_rcv(output logic [9:0] d);
    d = 10'h0;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge sclk);
      d[i] = txd;
    end
  endtask
endmodule

// >>> testbench/serial_channel_asserts.sv
// Port checker for the serial channel core
// Assumes bound to serial_channel_core; sees its ports only
`timescale 1ns/1ps
module serial_channel_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic txd,
  input wire logic sclk_oe,
  input wire logic receive_irq,
  input wire logic transmit_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Frame mode as last written; mode 00 is shift
  logic [1:0] mode_ff;
  logic async_on;
  assign async_on = mode_ff != 2'h0;
  // Track accepted control writes
  always_ff @(posedge clk)
    if (!rst_b)
      mode_ff <= 2'h0;
    else if (avs_write && !avs_waitrequest && avs_address == 4'h4
             && avs_byteenable[0])
      mode_ff <= avs_writedata[1:0];
  property p_wait;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address == 4'hC |->
      avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole not zero");
  property p_low_bit;
    $fell(txd) && async_on |=> !txd [*8];
  endproperty
  a_low_bit: assert property (p_low_bit) else $error("short low bit");
  property p_high_bit;
    $rose(txd) && async_on |=> txd [*8];
  endproperty
  a_high_bit: assert property (p_high_bit) else $error("short bit");
  property p_tx_pulse;
    transmit_irq |=> !transmit_irq;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx irq long");
  property p_rx_pulse;
    receive_irq |=> !receive_irq;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx irq long");
  property p_stop_irq;
    transmit_irq && async_on |=> txd [*8];
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("no stop");
  property p_no_oe;
    async_on |-> !sclk_oe;
  endproperty
  a_no_oe: assert property (p_no_oe) else $error("clock driven");
  c_rx: cover property (receive_irq);
  c_tx: cover property (transmit_irq);
  c_rd: cover property (avs_read && !avs_waitrequest);
endmodule

bind serial_channel_core serial_channel_asserts u_chk (.clk, .rst_b,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .txd, .sclk_oe, .receive_irq,
  .transmit_irq);

// >>> testbench/serial_channel_core_tb.sv
// Bench: register tasks, transmit and receive frame tests
// Assumes ticks every other cycle, so one bit is 32 clocks
`timescale 1ns/1ps
module serial_channel_core_tb;
  logic clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic txd, rxd, sclk, rx_irq, tx_irq;
  logic ticks = 1'b0;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [9:0] f;
  int n_fail = 0;
  int n_checks = 0;
  int n_rx_irq = 0;
  int n_tx_irq = 0;
  serial_channel_core dut (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .baud_tick(ticks),
    .fixed_tick(ticks), .timer0_match(ticks), .rxd_pin(rxd),
    .sclk_in_pin(1'b1), .clear_to_send_in(1'b0), .txd(txd),
    .sclk_out(sclk), .sclk_oe(), .receive_irq(rx_irq),
    .transmit_irq(tx_irq));
  remote_uart far (.clk(clk), .txd(txd), .sclk(sclk), .rxd(rxd));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Oversample tick on every other clock
  always @(posedge clk) ticks <= ~ticks;
  // Event pulses counted as the design raises them
  always @(posedge clk)
  begin
    if (rx_irq === 1'b1)
      n_rx_irq <= n_rx_irq + 1;
    if (tx_irq === 1'b1)
      n_tx_irq <= n_tx_irq + 1;
  end
  // Hold request until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Parity set up first, then data, then frame on the line
  task automatic txc(input logic [31:0] c, input logic [7:0] d,
                     input int n, input logic [9:0] e);
    bus(1'b1, 4'h4, c, q);
    fork
      far.rcv(n, f);
      bus(1'b1, 4'h0, {24'h0, d}, q);
    join
    chk(32'(f), 32'(e));
    repeat (40) @(posedge clk);
    bus(1'b0, 4'h8, 32'h0, q);
    chk(q & 32'h42, 32'h0);
  endtask
  // Frame in, then status under mask m, then data
  task automatic rxc(input logic [9:0] d, input int n, input logic s,
                     input logic [31:0] m, input logic [31:0] st,
                     input logic [7:0] dv);
    far.send(d, n, s);
    bus(1'b0, 4'h8, 32'h0, q);
    chk(q & m, st);
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q & 32'hFF, {24'h0, dv});
  endtask
  task final_report;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, far beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report;
  end
  initial
  begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(1'b0, 4'h4, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b1, 4'h4, 32'hFFFF, q);
    bus(1'b0, 4'h4, 32'h0, q);
    chk(q, 32'h0FFF);
    bus(1'b0, 4'hC, 32'h0, q);
    chk(q, 32'h0);
    $display("regs done");
    txc(32'hC6, 8'hA5, 9, 10'h3A5);
    txc(32'h49, 8'h35, 8, 10'h135);
    txc(32'h403, 8'h5A, 9, 10'h35A);
    $display("tx done");
    bus(1'b1, 4'h4, 32'h06, q);
    rxc(10'h3C, 8, 1'b1, 32'h39, 32'h01, 8'h3C);
    far.send(10'h11, 8, 1'b1);
    rxc(10'h22, 8, 1'b1, 32'h39, 32'h11, 8'h11);
    rxc(10'h44, 8, 1'b0, 32'h39, 32'h21, 8'h44);
    bus(1'b1, 4'h4, 32'hC6, q);
    rxc(10'h3C, 9, 1'b1, 32'h3D, 32'h09, 8'h3C);
    bus(1'b1, 4'h4, 32'h107, q);
    far.send(10'h0AA, 9, 1'b1);
    rxc(10'h155, 9, 1'b1, 32'h3D, 32'h05, 8'h55);
    $display("rx done");
    // Shift mode, own clock out: one byte to the far register
    bus(1'b1, 4'h4, 32'h04, q);
    fork
      far.shift_rcv(f);
      bus(1'b1, 4'h0, 32'hC3, q);
    join
    chk(32'(f), 32'hC3);
    repeat (8) @(posedge clk);
    chk(n_rx_irq, 5);
    chk(n_tx_irq, 4);
    $display("shift done");
    final_report;
  end
endmodule
